// ### verilog/pckw_pkg.sv
// Constants, types and register map of the port configuration and keypad wake block.
// Assumes an APB master with 32-bit data and a single 25 MHz CPU clock.
package pckw_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int NPIN        = 18;
    localparam int P0_BASE     = 0;
    localparam int P1_BASE     = 8;
    localparam int P2_BASE     = 16;
    localparam int PIN_OD_A    = 10;
    localparam int PIN_OD_B    = 11;
    localparam int PIN_RST_IN  = 13;
    localparam int PIN_OSC_OUT = 16;
    localparam int PIN_OSC_IN  = 17;

    // ****************************************************************
    // Output modes, {mode_sel_a, mode_sel_b}
    // ****************************************************************
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PUSH  = 2'h1;
    localparam logic [1:0] MODE_INPUT = 2'h2;
    localparam logic [1:0] MODE_ODRN  = 2'h3;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_P0_DATA   = 8'h00;
    localparam logic [7:0] ADDR_P1_DATA   = 8'h04;
    localparam logic [7:0] ADDR_P2_DATA   = 8'h08;
    localparam logic [7:0] ADDR_P0_MODE_A = 8'h0C;
    localparam logic [7:0] ADDR_P0_MODE_B = 8'h10;
    localparam logic [7:0] ADDR_P1_MODE_A = 8'h14;
    localparam logic [7:0] ADDR_P1_MODE_B = 8'h18;
    localparam logic [7:0] ADDR_P2_EXTRA  = 8'h1C;
    localparam logic [7:0] ADDR_P2_MODE_B = 8'h20;
    localparam logic [7:0] ADDR_KPD_EN    = 8'h24;
    localparam logic [7:0] ADDR_AUX       = 8'h28;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int P2X_CLKOUT  = 2;
    localparam int P2X_T0_TOG  = 3;
    localparam int P2X_T1_TOG  = 4;
    localparam int P2X_HYST0   = 5;
    localparam int AUX_KIRQ_EN = 0;
    localparam int AUX_KFLAG   = 1;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] KPD_EN_RST   = 8'h00;
    localparam int         STRONG_PU_CLK = 2;
    localparam logic [1:0] STRONG_PU_CYC = 2'(STRONG_PU_CLK);

    // Per-pin pad driver controls
    typedef struct packed {
        logic vweak_pu;
        logic weak_pu;
        logic strong_pu;
        logic pull_down;
    } pckw_drive_t;

    // Per-pin input stage controls
    typedef struct packed {
        logic in_en;
        logic hyst_en;
    } pckw_insel_t;

endpackage : pckw_pkg

// ### verilog/pckw_port_top.sv
// Three-port pad control with per-pin output modes and keypad wake detection.
// Assumes pads return their level on pin_level_i and obey the drive struct.
module pckw_port_top (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    // APB slave
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [7:0]                    paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    output logic [31:0]                        prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    // Nonvolatile options
    input  wire logic                          reset_level_high_opt_i,
    input  wire logic                          internal_reset_opt_i,
    input  wire logic                          xtal_osc_opt_i,
    // Pads
    input  wire logic [pckw_pkg::NPIN-1:0]     pin_level_i,
    output pckw_pkg::pckw_drive_t [pckw_pkg::NPIN-1:0] drive_o,
    output pckw_pkg::pckw_insel_t [pckw_pkg::NPIN-1:0] insel_o,
    // Enables for neighbouring blocks
    output logic                               t0_toggle_en_o,
    output logic                               t1_toggle_en_o,
    output logic                               clkout_en_o,
    // Keypad
    output logic                               keypad_irq_o,
    output logic                               keypad_wake_o
);
    import pckw_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [NPIN-1:0]  latch_reg;
    logic [NPIN-1:0]  latch_prev_reg;
    logic [7:0]       p0_mode_a_reg;
    logic [7:0]       p0_mode_b_reg;
    logic [7:0]       p1_mode_a_reg;
    logic [7:0]       p1_mode_b_reg;
    logic [7:0]       p2_extra_reg;
    logic [1:0]       p2_mode_b_reg;
    logic [7:0]       keypad_pin_enable_reg;
    logic             keypad_irq_en_reg;
    logic             keypad_event_flag;
    logic [NPIN-1:0]  sync1_reg;
    logic [NPIN-1:0]  sync2_reg;
    logic [1:0]       strong_cnt_reg [NPIN];
    logic [31:0]      rdata_reg;
    pckw_drive_t [NPIN-1:0] drive_next;
    pckw_insel_t [NPIN-1:0] insel_next;
    pckw_drive_t [NPIN-1:0] drive_reg;
    pckw_insel_t [NPIN-1:0] insel_reg;

    logic             wr_acc;
    logic             setup;
    logic             addr_ok;
    logic [NPIN-1:0]  mode_a;
    logic [NPIN-1:0]  mode_b;
    logic [NPIN-1:0]  pin_read;
    logic [2:0]       hyst_port;
    logic             keypad_hit;
    logic [31:0]      rdata_next;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign setup  = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i & addr_ok;

    always_comb begin
        case (paddr_i)
            ADDR_P0_DATA, ADDR_P1_DATA, ADDR_P2_DATA,
            ADDR_P0_MODE_A, ADDR_P0_MODE_B, ADDR_P1_MODE_A,
            ADDR_P1_MODE_B, ADDR_P2_EXTRA, ADDR_P2_MODE_B,
            ADDR_KPD_EN, ADDR_AUX: addr_ok = 1'b1;
            default:               addr_ok = 1'b0;
        endcase
    end

    // Zero wait states; read data was caught in the setup cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    assign prdata_o  = rdata_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr_i)
            ADDR_P0_DATA:   rdata_next[7:0] = pin_read[P0_BASE +: 8];
            ADDR_P1_DATA:   rdata_next[7:0] = pin_read[P1_BASE +: 8];
            ADDR_P2_DATA:   rdata_next[1:0] = pin_read[P2_BASE +: 2];
            ADDR_P0_MODE_A: rdata_next[7:0] = p0_mode_a_reg;
            ADDR_P0_MODE_B: rdata_next[7:0] = p0_mode_b_reg;
            ADDR_P1_MODE_A: rdata_next[7:0] = p1_mode_a_reg;
            ADDR_P1_MODE_B: rdata_next[7:0] = p1_mode_b_reg;
            ADDR_P2_EXTRA:  rdata_next[7:0] = p2_extra_reg;
            ADDR_P2_MODE_B: rdata_next[1:0] = p2_mode_b_reg;
            ADDR_KPD_EN:    rdata_next[7:0] = keypad_pin_enable_reg;
            ADDR_AUX: begin
                rdata_next[AUX_KIRQ_EN] = keypad_irq_en_reg;
                rdata_next[AUX_KFLAG]   = keypad_event_flag;
            end
            default:        rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // Port latches
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            // Reset level is a strap; sampling it under synchronous reset is clocked
            latch_reg <= {NPIN{reset_level_high_opt_i}};
        end else if (wr_acc) begin
            if (paddr_i == ADDR_P0_DATA) begin
                latch_reg[P0_BASE +: 8] <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P1_DATA) begin
                latch_reg[P1_BASE +: 8] <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P2_DATA) begin
                latch_reg[P2_BASE +: 2] <= pwdata_i[1:0];
            end
        end
    end

    // ****************************************************************
    // Mode registers
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            p0_mode_a_reg <= MODE_RST;
            p0_mode_b_reg <= MODE_RST;
            p1_mode_a_reg <= MODE_RST;
            p1_mode_b_reg <= MODE_RST;
            p2_extra_reg  <= MODE_RST;
            p2_mode_b_reg <= MODE_RST[1:0];
        end else if (wr_acc) begin
            if (paddr_i == ADDR_P0_MODE_A) begin
                p0_mode_a_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P0_MODE_B) begin
                p0_mode_b_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P1_MODE_A) begin
                p1_mode_a_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P1_MODE_B) begin
                p1_mode_b_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P2_EXTRA) begin
                p2_extra_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_P2_MODE_B) begin
                p2_mode_b_reg <= pwdata_i[1:0];
            end
        end
    end

    // Low two bits of the extra register are port 2 mode bits
    assign mode_a = {p2_extra_reg[1:0], p1_mode_a_reg, p0_mode_a_reg};
    assign mode_b = {p2_mode_b_reg, p1_mode_b_reg, p0_mode_b_reg};

    // Upper bits carry unrelated enables
    assign hyst_port      = p2_extra_reg[P2X_HYST0 +: 3];
    assign t0_toggle_en_o = p2_extra_reg[P2X_T0_TOG];
    assign t1_toggle_en_o = p2_extra_reg[P2X_T1_TOG];
    assign clkout_en_o    = p2_extra_reg[P2X_CLKOUT];

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_level_i;
            sync2_reg <= sync1_reg;
        end
    end

    // ****************************************************************
    // Strong pull-up pulse
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            latch_prev_reg <= {NPIN{reset_level_high_opt_i}};
            for (int k = 0; k < NPIN; k++) begin
                strong_cnt_reg[k] <= 2'h0;
            end
        end else begin
            latch_prev_reg <= latch_reg;
            for (int k = 0; k < NPIN; k++) begin
                if (latch_reg[k] & ~latch_prev_reg[k]) begin
                    strong_cnt_reg[k] <= STRONG_PU_CYC;
                end else if (strong_cnt_reg[k] != 2'h0) begin
                    strong_cnt_reg[k] <= strong_cnt_reg[k] - 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // Per-pin driver decode
    // ****************************************************************
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        logic [1:0] mode;
        logic       fixed_od;
        logic       fixed_in;
        logic       off;
        logic       lat;
        logic       quasi;

        assign fixed_od = (i == PIN_OD_A) || (i == PIN_OD_B);
        assign fixed_in = (i == PIN_RST_IN);
        assign lat      = latch_reg[i];

        always_comb begin
            if (fixed_od) begin
                mode = MODE_ODRN;
            end else if (fixed_in) begin
                mode = MODE_INPUT;
            end else begin
                mode = {mode_a[i], mode_b[i]};
            end
        end

        // Crystal takes both oscillator pins; reset pin needs internal reset
        assign off = (((i == PIN_OSC_OUT) || (i == PIN_OSC_IN)) && xtal_osc_opt_i)
                   || (fixed_in && !internal_reset_opt_i);
        assign quasi = (mode == MODE_QUASI) && !off;

        assign drive_next[i].vweak_pu  = quasi & lat;
        assign drive_next[i].weak_pu   = quasi & lat & sync2_reg[i];
        assign drive_next[i].strong_pu = !off &&
            ((quasi && strong_cnt_reg[i] != 2'h0)
             || (mode == MODE_PUSH && lat));
        // Input-only pads never pull; open drain only sinks
        assign drive_next[i].pull_down = !off && mode != MODE_INPUT && !lat;

        assign insel_next[i].in_en   = !off;
        assign insel_next[i].hyst_en = fixed_od || fixed_in
                                     || hyst_port[i / 8];
        assign pin_read[i] = sync2_reg[i] & !off;
    end

    // Registered pad controls keep pad glitches off the drivers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            drive_reg <= '0;
            insel_reg <= '0;
        end else begin
            drive_reg <= drive_next;
            insel_reg <= insel_next;
        end
    end

    assign drive_o = drive_reg;
    assign insel_o = insel_reg;

    // ****************************************************************
    // Keypad wake
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            keypad_pin_enable_reg <= KPD_EN_RST;
            keypad_irq_en_reg     <= 1'b0;
        end else if (wr_acc) begin
            if (paddr_i == ADDR_KPD_EN) begin
                keypad_pin_enable_reg <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_AUX) begin
                keypad_irq_en_reg <= pwdata_i[AUX_KIRQ_EN];
            end
        end
    end

    // Function is active while any pin is enabled
    assign keypad_hit = |(~sync2_reg[P0_BASE +: 8] & keypad_pin_enable_reg);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            keypad_event_flag <= 1'b0;
        end else if (keypad_hit) begin
            // Set beats a clear in the same cycle
            keypad_event_flag <= 1'b1;
        end else if (wr_acc && paddr_i == ADDR_AUX && !pwdata_i[AUX_KFLAG]) begin
            keypad_event_flag <= 1'b0;
        end
    end

    assign keypad_irq_o  = keypad_event_flag & keypad_irq_en_reg;
    // Wake is the flag gated by the interrupt enable, so power-down exit needs keypad_irq_en_reg set
    assign keypad_wake_o = keypad_irq_o;

endmodule : pckw_port_top

// ### verif/pckw_checker.sv
// Port-level assertions for the pad control and keypad wake block.
// Assumes it is bound onto pckw_port_top and sees only its ports.
module pckw_checker
import pckw_pkg::*;
(
    // Clock and reset
    input wire logic                  clock_i,
    input wire logic                  rst_i,
    // APB
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [7:0]            paddr_i,
    input wire logic                  pslverr_o,
    // Options and pads
    input wire logic                  internal_reset_opt_i,
    input wire logic                  xtal_osc_opt_i,
    input wire logic [NPIN-1:0]       pin_level_i,
    input wire pckw_drive_t [NPIN-1:0] drive_o,
    input wire pckw_insel_t [NPIN-1:0] insel_o,
    // Keypad
    input wire logic                  keypad_irq_o,
    input wire logic                  keypad_wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ********************************
    // Helpers
    // ********************************
    // Skips the cycles whose history still reaches into reset
    logic [2:0] settle_q;
    logic       map_w;
    assign map_w = (paddr_i <= ADDR_AUX) && (paddr_i[1:0] == 2'h0);
    always_ff @(posedge clock_i) begin
        if (rst_i)
            settle_q <= 3'h0;
        else if (settle_q != 3'h7)
            settle_q <= settle_q + 3'h1;
    end

    // ********************************
    // Assertions
    // ********************************
    apb_err_a: assert property (pslverr_o == (psel_i && penable_i && !map_w))
        else $error("slave error flag wrong");
    kpd_wake_a: assert property (keypad_wake_o == keypad_irq_o)
        else $error("wake differs from keypad request");
    kpd_sticky_a: assert property (
        $fell(keypad_irq_o) |-> $past(psel_i && penable_i && pwrite_i && paddr_i == ADDR_AUX))
        else $error("keypad request dropped without a write");
    for (genvar k = 0; k < NPIN; k++) begin : g_pin
        strong_pulse_a: assert property (
            $rose(drive_o[k].strong_pu) && drive_o[k].vweak_pu
            |=> drive_o[k].strong_pu ##1 !drive_o[k].strong_pu)
            else $error("strong pull-up pulse length wrong");
        weak_follow_a: assert property (
            settle_q == 3'h7 && drive_o[k].weak_pu
            |-> drive_o[k].vweak_pu && $past(pin_level_i[k], 3))
            else $error("weak pull-up without latch and pin high");
        drive_excl_a: assert property (
            drive_o[k].pull_down
            |-> !(drive_o[k].vweak_pu || drive_o[k].weak_pu || drive_o[k].strong_pu))
            else $error("pull-up and pull-down together");
    end
    fixed_od_a: assert property (
        {drive_o[PIN_OD_A][3:1], drive_o[PIN_OD_B][3:1]} == 6'h00)
        else $error("fixed open drain pin pulls up");
    rst_pin_a: assert property (
        settle_q > 3'h2 && $stable(internal_reset_opt_i)
        |-> insel_o[PIN_RST_IN].in_en == internal_reset_opt_i && drive_o[PIN_RST_IN] == 4'h0)
        else $error("reset-shared pin wrong");
    osc_off_a: assert property (
        xtal_osc_opt_i && $past(xtal_osc_opt_i)
        |-> {drive_o[PIN_OSC_IN], drive_o[PIN_OSC_OUT]} == 8'h00
        && {insel_o[PIN_OSC_IN], insel_o[PIN_OSC_OUT]} == 4'h0)
        else $error("oscillator pins not disabled");
    fixed_hyst_a: assert property (
        settle_q > 3'h2 |-> insel_o[PIN_OD_A].hyst_en && insel_o[PIN_OD_B].hyst_en
        && insel_o[PIN_RST_IN].hyst_en)
        else $error("fixed pin without hysteresis");
    strong_c: cover property ($rose(drive_o[0].strong_pu) && drive_o[0].vweak_pu);
    kpd_c: cover property ($rose(keypad_irq_o));
    err_c: cover property (pslverr_o);
endmodule : pckw_checker

// ### verif/pckw_pad_model.sv
// Board model: pads, keypad switches, board pull-ups and floating pins.
// Assumes the per-pin drive struct of the pad control block.
module pckw_pad_model
import pckw_pkg::*;
(
    input wire logic                   clock_i,
    input wire pckw_drive_t [NPIN-1:0] drive_i,
    input wire logic [NPIN-1:0]        key_low_i,
    input wire logic [NPIN-1:0]        ext_pu_i,
    output logic [NPIN-1:0]            level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins wander so a stale level never passes for a real one
    logic [NPIN-1:0] float_q = '0;
    always_ff @(posedge clock_i) float_q <= ~float_q;
    always_comb begin
        for (int k = 0; k < NPIN; k++) begin
            if (drive_i[k].pull_down || key_low_i[k])
                level_o[k] = 1'b0;
            else if (drive_i[k].vweak_pu || drive_i[k].weak_pu || drive_i[k].strong_pu)
                level_o[k] = 1'b1;
            else if (ext_pu_i[k])
                level_o[k] = 1'b1;
            else
                level_o[k] = float_q[k];
        end
    end
endmodule : pckw_pad_model

// ### verif/pckw_tb.sv
// Self-checking bench for the pad control and keypad wake block.
// Assumes the checker and pad model are compiled before it.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pckw_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, err, t0_toggle_en_o, t1_toggle_en_o, clkout_en_o;
    logic keypad_irq_o, keypad_wake_o, lvl_hi = 1'b1, int_rst = 1'b0, xtal = 1'b0;
    // Board resistors on the fixed open drain pins
    logic [NPIN-1:0] pin_level_i, key_low = '0, ext_pu = 18'h00C00;
    pckw_drive_t [NPIN-1:0] drive_o;
    pckw_insel_t [NPIN-1:0] insel_o;
    int miscompares = 0, num_checks = 0;

    always #20 clock_i = ~clock_i;

    pckw_port_top i_dut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .reset_level_high_opt_i(lvl_hi),
        .internal_reset_opt_i(int_rst), .xtal_osc_opt_i(xtal), .pin_level_i, .drive_o,
        .insel_o, .t0_toggle_en_o, .t1_toggle_en_o, .clkout_en_o, .keypad_irq_o,
        .keypad_wake_o);
    pckw_pad_model i_pads (.clock_i, .drive_i(drive_o), .key_low_i(key_low),
        .ext_pu_i(ext_pu), .level_o(pin_level_i));

    // ********************************
    // Tasks
    // ********************************
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 64);
        if (pready_o !== 1'b1) begin
            miscompares++;
            conclude();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc

    task automatic do_reset(input logic hi);
        @(posedge clock_i);
        rst_i <= 1'b1;
        lvl_hi <= hi;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        cyc(5);
    endtask : do_reset

    initial begin
        #2000000;
        miscompares++;
        conclude();
    end

    // ********************************
    // Sequence
    // ********************************
    initial begin
        do_reset(1'b1);
        `CHK(drive_o[0], 4'hC)
        apb(1'b0, ADDR_P0_MODE_A, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, ADDR_P0_DATA, 32'h0);
        cyc(2);
        `CHK(drive_o[0], 4'h1)
        apb(1'b1, ADDR_P0_DATA, 32'hFF);
        for (int c = 0; c < 4; c++) begin
            cyc(1);
            `CHK(drive_o[0].strong_pu, 1'(c == 1 || c == 2))
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_P0_MODE_A, m[1] ? 32'hFF : 32'h0);
            apb(1'b1, ADDR_P0_MODE_B, m[0] ? 32'hFF : 32'h0);
            for (int l = 0; l < 2; l++) begin
                apb(1'b1, ADDR_P0_DATA, l ? 32'hFF : 32'h0);
                cyc(5);
                `CHK(drive_o[3].pull_down, 1'(l == 0 && m != MODE_INPUT))
                `CHK(drive_o[3].strong_pu, 1'(l == 1 && m == MODE_PUSH))
                `CHK(drive_o[3].vweak_pu, 1'(l == 1 && m == MODE_QUASI))
                `CHK(drive_o[3].weak_pu, 1'(l == 1 && m == MODE_QUASI))
            end
        end
        apb(1'b1, ADDR_P0_MODE_A, 32'h0);
        apb(1'b1, ADDR_P0_MODE_B, 32'h0);
        apb(1'b1, ADDR_KPD_EN, 32'h08);
        apb(1'b1, ADDR_AUX, 32'h1);
        key_low <= 18'h10;
        cyc(6);
        `CHK(keypad_irq_o, 1'b0)
        `CHK(drive_o[4], 4'h8)
        @(posedge clock_i);
        key_low <= 18'h18;
        cyc(6);
        `CHK({keypad_irq_o, keypad_wake_o}, 2'h3)
        apb(1'b0, ADDR_P0_DATA, 32'h0);
        `CHK(rd, 32'hE7)
        // Clear while the key is still down must lose; request masked by enable
        apb(1'b1, ADDR_AUX, 32'h0);
        apb(1'b0, ADDR_AUX, 32'h0);
        `CHK({keypad_irq_o, rd}, 33'h2)
        apb(1'b1, ADDR_AUX, 32'h1);
        key_low <= '0;
        cyc(6);
        `CHK(keypad_irq_o, 1'b1)
        apb(1'b1, ADDR_AUX, 32'h1);
        cyc(1);
        `CHK(keypad_irq_o, 1'b0)
        apb(1'b1, ADDR_P1_MODE_B, 32'hFF);
        apb(1'b1, ADDR_P1_DATA, 32'h0);
        cyc(3);
        `CHK({drive_o[PIN_OD_A], drive_o[PIN_RST_IN]}, 8'h10)
        apb(1'b1, ADDR_P1_DATA, 32'hFF);
        cyc(3);
        `CHK({drive_o[9], drive_o[PIN_OD_B]}, 8'h20)
        apb(1'b0, ADDR_P1_DATA, 32'h0);
        `CHK(rd, 32'hDF)
        int_rst <= 1'b1;
        ext_pu <= 18'h02C00;
        cyc(5);
        `CHK(insel_o[PIN_RST_IN], 2'h3)
        apb(1'b1, ADDR_P2_EXTRA, 32'h3C);
        cyc(2);
        `CHK({t1_toggle_en_o, t0_toggle_en_o, clkout_en_o}, 3'h7)
        `CHK({insel_o[0].hyst_en, insel_o[8].hyst_en}, 2'h2)
        apb(1'b1, ADDR_P2_EXTRA, 32'h08);
        cyc(2);
        `CHK({t1_toggle_en_o, t0_toggle_en_o, clkout_en_o}, 3'h2)
        `CHK(drive_o[PIN_OSC_OUT].vweak_pu, 1'b1)
        apb(1'b1, ADDR_P2_MODE_B, 32'h1);
        cyc(2);
        `CHK(drive_o[PIN_OSC_OUT], 4'h2)
        apb(1'b0, ADDR_P2_DATA, 32'h0);
        `CHK(rd, 32'h3)
        @(posedge clock_i);
        xtal <= 1'b1;
        cyc(3);
        `CHK({drive_o[PIN_OSC_IN], drive_o[PIN_OSC_OUT], insel_o[PIN_OSC_IN]}, 10'h000)
        apb(1'b0, ADDR_P2_DATA, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h2C, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        do_reset(1'b0);
        `CHK(drive_o[0], 4'h1)
        apb(1'b0, ADDR_P1_MODE_B, 32'h0);
        `CHK({keypad_irq_o, rd}, 33'h0)
        conclude();
    end
endmodule : tb

bind pckw_port_top pckw_checker i_chk (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pslverr_o, .internal_reset_opt_i, .xtal_osc_opt_i, .pin_level_i, .drive_o,
    .insel_o, .keypad_irq_o, .keypad_wake_o);
